// File: include/dac_ctrl_pkg.sv
package dac_ctrl_pkg;

  // Frame layout: direction bit, three address bits, twenty data bits.
  localparam int FRAME_BITS = 24;
  localparam int RW_BIT = 23;
  localparam int ADDR_MSB = 22;
  localparam int ADDR_LSB = 20;
  localparam int CODE_BITS = 18;
  localparam int CODE_MSB = 19;
  localparam int CODE_LSB = 2;
  localparam int CNT_BITS = 5;

  typedef logic [2:0] reg_addr_t;
  typedef logic [CODE_BITS-1:0] code_t;

  // Register addresses carried in the frame address field.
  localparam reg_addr_t ADDR_DAC = 3'h1;
  localparam reg_addr_t ADDR_CTRL = 3'h2;
  localparam reg_addr_t ADDR_CLEAR_CODE = 3'h3;
  localparam reg_addr_t ADDR_SW_PINS = 3'h4;

  // Pin emulation bits of the write-only register.
  localparam int SW_LOAD_BIT = 0;
  localparam int SW_CLEAR_BIT = 1;
  localparam int SW_RESET_BIT = 2;

  // Control register bit positions.
  localparam int CTRL_FB_SEL_BIT = 1;
  localparam int CTRL_GND_CLAMP_BIT = 2;
  localparam int CTRL_THREE_STATE_BIT = 3;
  localparam int CTRL_CODE_FMT_BIT = 4;
  localparam int CTRL_READOUT_OFF_BIT = 5;

  // Power-on values; a DAC code of 18'h20000, negative full scale in twos complement, is the negative reference.
  localparam logic CTRL_FB_SEL_RST = 1'h1;
  localparam logic CTRL_GND_CLAMP_RST = 1'h1;
  localparam logic CTRL_THREE_STATE_RST = 1'h1;
  localparam logic CTRL_CODE_FMT_RST = 1'h0;
  localparam logic CTRL_READOUT_OFF_RST = 1'h0;
  localparam code_t DAC_REG_RST = 18'h20000;
  localparam code_t CLEAR_CODE_RST = 18'h00000;
  localparam logic [1:0] PIN_IDLE = 2'h3;

  typedef enum logic [1:0] {
    OUT_NORMAL = 2'b00,
    OUT_CLAMPED = 2'b01,
    OUT_FLOATING = 2'b10
  } out_state_t;

  // Converts the DAC register to the straight binary code the converter core needs.
  function automatic code_t to_core_code(input code_t code, input logic offset_binary);
    to_core_code = offset_binary ? code : {~code[CODE_BITS-1], code[CODE_BITS-2:0]};
  endfunction

endpackage

// File: include/serial_frame_if.sv
`timescale 1ns/1ps
interface serial_frame_if;
  import dac_ctrl_pkg::*;
  logic [FRAME_BITS-1:0] frame_word;
  logic frame_toggle;
  logic [FRAME_BITS-1:0] read_word;
  logic readout_off;
  modport link (output frame_word, frame_toggle, input read_word, readout_off);
  modport core (input frame_word, frame_toggle, output read_word, readout_off);
endinterface

// File: verif/dac_clear_load_output_state_ctrl_bench.sv
`timescale 1ns/1ps
module dac_clear_load_output_state_ctrl_bench;
  import dac_ctrl_pkg::*;
  logic ref_clk;
  logic sys_rst;
  logic link_clk, frame_sync_n, serial_in, serial_out, serial_out_oe_n;
  logic dac_load_strobe_n, clear_to_code_n;
  logic [CODE_BITS-1:0] dac_code;
  out_state_t output_state;
  logic feedback_resistor_select, amp_power_down;
  int failures;
  int total_checks;
  logic [FRAME_BITS-1:0] rd;

  dac_clear_load_output_state_ctrl dut (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .link_clk(link_clk),
    .frame_sync_n(frame_sync_n),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n),
    .dac_load_strobe_n(dac_load_strobe_n),
    .clear_to_code_n(clear_to_code_n),
    .dac_code(dac_code),
    .output_state(output_state),
    .feedback_resistor_select(feedback_resistor_select),
    .amp_power_down(amp_power_down)
  );

  host_frame_model host (
    .link_clk(link_clk),
    .frame_sync_n(frame_sync_n),
    .serial_in(serial_in),
    .serial_out(serial_out)
  );

  // Core clock at 250 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input reg_addr_t a, input logic [19:0] d);
    host.xfer({1'b0, a, d}, rd);
  endtask

  // A read needs a second frame to shift the captured word back out.
  task automatic rdreg(input reg_addr_t a, output logic [23:0] v);
    host.xfer({1'b1, a, 20'h00000}, rd);
    host.xfer(24'h800000, v);
  endtask

  function automatic logic [19:0] ctl(logic tri_s, logic clamp, logic fb, logic fmt);
    return {14'h0000, 1'b0, fmt, tri_s, clamp, fb, 1'b0};
  endfunction

  // Pins change only at the falling core edge and then settle past the synchronisers.
  task automatic pins(input logic load_n, input logic clr_n);
    @(negedge ref_clk);
    dac_load_strobe_n = load_n;
    clear_to_code_n = clr_n;
    repeat (8) @(negedge ref_clk);
  endtask

  task automatic t_power_on();
    logic [23:0] v;
    chk("state", OUT_CLAMPED, output_state);
    chk("code", 24'h000000, dac_code);
    chk("fb", 24'h000001, feedback_resistor_select);
    chk("amp_off", 24'h000001, amp_power_down);
    chk("oe_n", 24'h000000, serial_out_oe_n);
    repeat (100) @(negedge ref_clk);
    chk("state_held", OUT_CLAMPED, output_state);
    rdreg(ADDR_CLEAR_CODE, v);
    chk("clear_rb", 24'hB00000, v);
    rdreg(ADDR_SW_PINS, v);
    chk("pins_rb", 24'hC00000, v);
    rdreg(ADDR_DAC, v);
    chk("dac_rb", 24'h980000, v);
    rdreg(ADDR_CTRL, v);
    chk("ctrl_rb", 24'hA0000E, v);
    $display("t_power_on done");
  endtask

  task automatic t_out_states();
    logic ts;
    logic cl;
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b0));
    chk("normal", OUT_NORMAL, output_state);
    chk("neg_ref", 24'h000000, dac_code);
    for (int i = 0; i < 4; i++) begin
      ts = i[1];
      cl = i[0];
      wr(ADDR_CTRL, ctl(ts, cl, 1'b1, 1'b0));
      chk("state_tbl", cl ? OUT_CLAMPED : (ts ? OUT_FLOATING : OUT_NORMAL), output_state);
    end
    // Readout off reaches the link side only during the next frame, through its synchroniser.
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b0) | 20'h00020);
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b0) | 20'h00020);
    chk("oe_off", 24'h000001, serial_out_oe_n);
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b0));
    chk("fb0", 24'h000000, feedback_resistor_select);
    chk("amp_on", 24'h000000, amp_power_down);
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b0));
    chk("fb1", 24'h000001, feedback_resistor_select);
    chk("amp_off", 24'h000001, amp_power_down);
    chk("oe_on", 24'h000000, serial_out_oe_n);
    $display("t_out_states done");
  endtask

  task automatic t_load();
    wr(ADDR_DAC, {18'h00005, 2'b00});
    chk("pending", 24'h000000, dac_code);
    wr(ADDR_SW_PINS, 20'h00001);
    chk("loaded", 24'h020005, dac_code);
    $display("t_load done");
  endtask

  task automatic t_clear();
    logic [23:0] v;
    wr(ADDR_CLEAR_CODE, {18'h1FFFF, 2'b11});
    rdreg(ADDR_CLEAR_CODE, v);
    chk("clear_rb", {1'b1, 3'h3, 18'h1FFFF}, {2'b00, v[23:2]});
    wr(ADDR_SW_PINS, 20'h00002);
    chk("clear_2c", 24'h03FFFF, dac_code);
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b1));
    wr(ADDR_CLEAR_CODE, {18'h00007, 2'b00});
    wr(ADDR_SW_PINS, 20'h00002);
    chk("clear_ob", 24'h000007, dac_code);
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b0));
    chk("clear_2c7", 24'h020007, dac_code);
    $display("t_clear done");
  endtask

  task automatic t_pin_block();
    wr(ADDR_SW_PINS, 20'h00001);
    chk("reload", 24'h020005, dac_code);
    pins(1'b0, 1'b1);
    wr(ADDR_SW_PINS, 20'h00002);
    chk("clear_blocked", 24'h020005, dac_code);
    // With the load pin held low a DAC write goes straight through.
    wr(ADDR_DAC, {18'h00006, 2'b00});
    chk("follow", 24'h020006, dac_code);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b0);
    chk("pin_clear", 24'h020007, dac_code);
    wr(ADDR_DAC, {18'h00009, 2'b00});
    wr(ADDR_SW_PINS, 20'h00001);
    chk("load_blocked", 24'h020007, dac_code);
    pins(1'b1, 1'b1);
    wr(ADDR_SW_PINS, 20'h00001);
    chk("load_after", 24'h020009, dac_code);
    $display("t_pin_block done");
  endtask

  task automatic t_sw_reset();
    logic [23:0] v;
    wr(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b0));
    wr(ADDR_SW_PINS, 20'h00004);
    chk("rst_state", OUT_CLAMPED, output_state);
    chk("rst_code", 24'h000000, dac_code);
    chk("rst_fb", 24'h000001, feedback_resistor_select);
    rdreg(ADDR_CLEAR_CODE, v);
    chk("rst_clear", 24'hB00000, v);
    $display("t_sw_reset done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A hung run is cut short and counted as a mismatch.
  initial begin
    #200000;
    failures++;
    results();
  end

  // Main sequence: reset for eight cycles, then each scenario in turn.
  initial begin
    failures = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    dac_load_strobe_n = 1'b1;
    clear_to_code_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    t_power_on();
    t_out_states();
    t_load();
    t_clear();
    t_pin_block();
    t_sw_reset();
    results();
  end
endmodule

// File: verif/host_frame_model.sv
`timescale 1ns/1ps
module host_frame_model
  import dac_ctrl_pkg::*;
(
  output logic link_clk,
  output logic frame_sync_n,
  output logic serial_in,
  input wire logic serial_out
);
  // The host idles with the select high and its serial clock parked low.
  initial begin
    link_clk = 1'b0;
    frame_sync_n = 1'b1;
    serial_in = 1'b0;
  end

  // Shifts one frame out and collects the readback bits of the previous frame.
  // The clock runs only inside a frame, so the device never sees stray edges.
  task automatic xfer(input logic [FRAME_BITS-1:0] word, output logic [FRAME_BITS-1:0] rd);
    frame_sync_n = 1'b0;
    for (int k = FRAME_BITS - 1; k >= 0; k--) begin
      serial_in = word[k];
      #7.5 link_clk = 1'b1;
      #3 rd[k] = serial_out;
      #4.5 link_clk = 1'b0;
    end
    #2 frame_sync_n = 1'b1;
    // The data line has no pull, so show the inverse rather than a stale value.
    serial_in = ~word[0];
    // The gap leaves the core well over four cycles to take the frame.
    #30;
  endtask
endmodule

// File: verilog/dac_clear_load_output_state_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - The pin emulation register is write-only and a 1 in bit 2, 1 or 0 acts as a low pulse on reset, clear or load.
// - A software load moves the pending code into the DAC register and so updates the output.
// - A software clear copies the 18-bit clear code, taken from frame bits 19 to 2, into the DAC register.
// - The clear code is read with whatever DAC register coding is currently selected.
// - A software reset returns every register and the clamped output to the power-on state.
// - A software clear has no effect while the load strobe pin is low.
// - A software load has no effect while the clear pin is low.
// - Power-on reset sets every register to its default.
// - After power-on the DAC is three-stated and its output clamped to ground.
// - The clamped state holds until the host writes the control bits.
// - On entering normal mode the output sits at the negative reference unless another code was written.
// - Clamp set gives the grounded clamp, else three-state set floats the output, else normal mode.
// - The frame MSB is 0 for a register write and 1 for a register read.
module dac_clear_load_output_state_ctrl
  import dac_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic frame_sync_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  input wire logic dac_load_strobe_n,
  input wire logic clear_to_code_n,
  output logic [CODE_BITS-1:0] dac_code,
  output out_state_t output_state,
  output logic feedback_resistor_select,
  output logic amp_power_down
);
  typedef struct packed {
    code_t in_reg;
    code_t dac_reg;
    code_t clear_code;
    logic fb_sel;
    logic gnd_clamp;
    logic three_state;
    logic code_fmt;
    logic readout_off;
    logic [FRAME_BITS-1:0] read_word;
    logic last_toggle;
    logic soft_rst;
    logic load_pin_prev;
    logic clear_pin_prev;
    code_t dac_code;
    out_state_t out_state;
    logic fb_out;
    logic amp_pd;
  } core_state_t;

  // Power-on image of the whole core; the soft reset reloads this, except last_toggle, which takes toggle_s.
  localparam core_state_t CORE_RST = '{
    in_reg: DAC_REG_RST,
    dac_reg: DAC_REG_RST,
    clear_code: CLEAR_CODE_RST,
    fb_sel: CTRL_FB_SEL_RST,
    gnd_clamp: CTRL_GND_CLAMP_RST,
    three_state: CTRL_THREE_STATE_RST,
    code_fmt: CTRL_CODE_FMT_RST,
    readout_off: CTRL_READOUT_OFF_RST,
    read_word: '0,
    last_toggle: 1'b0,
    soft_rst: 1'b0,
    load_pin_prev: PIN_IDLE[1],
    clear_pin_prev: PIN_IDLE[0],
    dac_code: to_core_code(DAC_REG_RST, CTRL_CODE_FMT_RST),
    out_state: OUT_CLAMPED,
    fb_out: CTRL_FB_SEL_RST,
    amp_pd: CTRL_FB_SEL_RST
  };

  // True for a write frame aimed at the given register.
  function automatic logic is_write_to(input logic [FRAME_BITS-1:0] w, input reg_addr_t a);
    is_write_to = !w[RW_BIT] && (w[ADDR_MSB:ADDR_LSB] == a);
  endfunction

  serial_frame_if link_bus ();

  core_state_t cur;
  core_state_t nxt;
  logic [1:0] pins_s;
  logic toggle_s;
  logic load_pin;
  logic clear_pin;
  logic new_frame;
  logic [FRAME_BITS-1:0] word;
  code_t word_code;
  logic sw_wr;
  logic sw_load;
  logic sw_clear;
  logic sw_reset;
  logic load_fall;
  logic clear_fall;
  logic do_load;
  logic do_clear;
  logic [CODE_LSB-1:0] pad;

  // The serial side runs on the host's clock and hands each finished frame over by a toggle.
  serial_frame_shifter u_shifter (
    .link_clk(link_clk),
    .frame_sync_n(frame_sync_n),
    .serial_in(serial_in),
    .sys_rst(sys_rst),
    .bus(link_bus.link),
    .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n)
  );

  // Strobe pins are asynchronous to the core clock and pass two flops first.
  sync_2ff #(.WIDTH(2), .RST_VAL(PIN_IDLE)) u_pin_sync (
    .clk(ref_clk),
    .rst(sys_rst),
    .d({dac_load_strobe_n, clear_to_code_n}),
    .q(pins_s)
  );

  // The frame toggle is an event, so only its synchronised edge is trusted.
  sync_2ff #(.WIDTH(1), .RST_VAL(1'h0)) u_toggle_sync (
    .clk(ref_clk),
    .rst(sys_rst),
    .d(link_bus.frame_toggle),
    .q(toggle_s)
  );

  // Frame decode; the word is stable because the shifter stops after the last bit.
  assign load_pin = pins_s[1];
  assign clear_pin = pins_s[0];
  assign new_frame = toggle_s != cur.last_toggle;
  assign word = link_bus.frame_word;
  assign word_code = word[CODE_MSB:CODE_LSB];
  assign pad = '0;
  assign sw_wr = new_frame && is_write_to(word, ADDR_SW_PINS);
  assign sw_load = sw_wr && word[SW_LOAD_BIT];
  assign sw_clear = sw_wr && word[SW_CLEAR_BIT];
  assign sw_reset = sw_wr && word[SW_RESET_BIT];
  assign load_fall = cur.load_pin_prev && !load_pin;
  assign clear_fall = cur.clear_pin_prev && !clear_pin;

  // A software bit stands in for a falling pin edge; both loads are blocked by the clear pin, but only the software clear by the load pin.
  assign do_load = (load_fall || sw_load) && clear_pin;
  assign do_clear = clear_fall || (sw_clear && load_pin);

  // All next-state logic; clear is applied after load so that a clear wins a tie.
  always_comb begin
    nxt = cur;
    nxt.last_toggle = toggle_s;
    nxt.load_pin_prev = load_pin;
    nxt.clear_pin_prev = clear_pin;
    if (new_frame && is_write_to(word, ADDR_DAC)) begin
      nxt.in_reg = word_code;
      // With the load pin held low and the clear pin high the DAC register follows writes directly.
      if (!load_pin && clear_pin) begin
        nxt.dac_reg = word_code;
      end
    end
    if (new_frame && is_write_to(word, ADDR_CTRL)) begin
      nxt.fb_sel = word[CTRL_FB_SEL_BIT];
      nxt.gnd_clamp = word[CTRL_GND_CLAMP_BIT];
      nxt.three_state = word[CTRL_THREE_STATE_BIT];
      nxt.code_fmt = word[CTRL_CODE_FMT_BIT];
      nxt.readout_off = word[CTRL_READOUT_OFF_BIT];
    end
    if (new_frame && is_write_to(word, ADDR_CLEAR_CODE)) begin
      nxt.clear_code = word_code;
    end
    // A read frame prepares the word shifted out during the next frame.
    if (new_frame && word[RW_BIT]) begin
      nxt.read_word = '0;
      nxt.read_word[RW_BIT] = 1'b1;
      nxt.read_word[ADDR_MSB:ADDR_LSB] = word[ADDR_MSB:ADDR_LSB];
      case (word[ADDR_MSB:ADDR_LSB])
        ADDR_DAC: begin
          nxt.read_word[CODE_MSB:0] = {cur.dac_reg, pad};
        end
        ADDR_CTRL: begin
          nxt.read_word[CTRL_FB_SEL_BIT] = cur.fb_sel;
          nxt.read_word[CTRL_GND_CLAMP_BIT] = cur.gnd_clamp;
          nxt.read_word[CTRL_THREE_STATE_BIT] = cur.three_state;
          nxt.read_word[CTRL_CODE_FMT_BIT] = cur.code_fmt;
          nxt.read_word[CTRL_READOUT_OFF_BIT] = cur.readout_off;
        end
        ADDR_CLEAR_CODE: begin
          nxt.read_word[CODE_MSB:0] = {cur.clear_code, pad};
        end
        default: begin
          nxt.read_word[CODE_MSB:0] = '0;
        end
      endcase
    end
    if (do_load) begin
      nxt.dac_reg = cur.in_reg;
    end
    if (do_clear) begin
      nxt.dac_reg = cur.clear_code;
    end
    if (sw_reset) begin
      nxt.soft_rst = 1'b1;
    end
    // Outputs are registered copies, one cycle behind the state they show.
    nxt.dac_code = to_core_code(cur.dac_reg, cur.code_fmt);
    if (cur.gnd_clamp) begin
      nxt.out_state = OUT_CLAMPED;
    end else if (cur.three_state) begin
      nxt.out_state = OUT_FLOATING;
    end else begin
      nxt.out_state = OUT_NORMAL;
    end
    nxt.fb_out = cur.fb_sel;
    nxt.amp_pd = cur.fb_sel;
    // Soft reset takes one extra cycle so the frame that asked for it finishes first.
    if (sys_rst || cur.soft_rst) begin
      nxt = CORE_RST;
      nxt.last_toggle = toggle_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    cur <= nxt;
  end

  assign link_bus.read_word = cur.read_word;
  assign link_bus.readout_off = cur.readout_off;
  assign dac_code = cur.dac_code;
  assign output_state = cur.out_state;
  assign feedback_resistor_select = cur.fb_out;
  assign amp_power_down = cur.amp_pd;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // A software load with the clear pin high takes the pending code in one cycle.
  sw_load_a: assert property (
    (sw_load && clear_pin && !do_clear && !cur.soft_rst) |=> (cur.dac_reg == $past(cur.in_reg))
  ) else $error("software load did not move pending code");

  // A software clear with the load pin high takes the clear code.
  sw_clear_a: assert property (
    (sw_clear && load_pin && !cur.soft_rst) |=> (cur.dac_reg == $past(cur.clear_code))
  ) else $error("software clear did not load the clear code");

  // A software clear alone while the load pin is low leaves the DAC register alone.
  clear_blocked_a: assert property (
    (sw_clear && !sw_load && !load_pin && !load_fall && !clear_fall && !cur.soft_rst)
      |=> $stable(cur.dac_reg)
  ) else $error("software clear acted with load pin low");

  // A software load while the clear pin is low leaves the DAC register alone.
  load_blocked_a: assert property (
    (sw_load && !sw_clear && !clear_pin && !clear_fall && !cur.soft_rst) |=> $stable(cur.dac_reg)
  ) else $error("software load acted with clear pin low");

  // A software reset brings back the clamped, three-stated power-on state two cycles later.
  soft_reset_a: assert property (
    sw_reset |-> ##2 (cur.gnd_clamp && cur.three_state && cur.dac_reg == DAC_REG_RST
      && cur.clear_code == CLEAR_CODE_RST && cur.out_state == OUT_CLAMPED)
  ) else $error("software reset did not restore defaults");

  // Right after reset the output is clamped and the code sits at the negative reference.
  power_on_clamp_a: assert property (
    $past(sys_rst) |-> (output_state == OUT_CLAMPED && cur.gnd_clamp && cur.three_state
      && feedback_resistor_select && amp_power_down)
  ) else $error("power-on state is not clamped");

  power_on_code_a: assert property (
    $past(sys_rst) |-> (cur.dac_reg == DAC_REG_RST && dac_code == '0)
  ) else $error("power-on code is not the negative reference");

  // The clamp bit only drops when a control frame writes it.
  clamp_hold_a: assert property (
    (cur.gnd_clamp && !(new_frame && is_write_to(word, ADDR_CTRL))) |=> cur.gnd_clamp
  ) else $error("clamp released without a control write");

  // The output state follows the two control bits one cycle later.
  state_clamp_a: assert property (
    (cur.gnd_clamp && !cur.soft_rst) |=> (output_state == OUT_CLAMPED)
  ) else $error("clamp bit did not clamp the output");

  state_float_a: assert property (
    (cur.three_state && !cur.gnd_clamp && !cur.soft_rst) |=> (output_state == OUT_FLOATING)
  ) else $error("three-state bit did not float the output");

  // The core code is the DAC register converted by the coding in force.
  code_format_a: assert property (
    !cur.soft_rst |=> (dac_code == to_core_code($past(cur.dac_reg), $past(cur.code_fmt)))
  ) else $error("core code does not follow the selected coding");

  // A clear code write frame stores bits 19 to 2 in the next cycle.
  clear_code_write_a: assert property (
    (new_frame && is_write_to(word, ADDR_CLEAR_CODE) && !cur.soft_rst)
      |=> (cur.clear_code == $past(word_code))
  ) else $error("clear code frame was not stored");

  // A read frame marks the readback word as a read of the same address.
  read_frame_a: assert property (
    (new_frame && word[RW_BIT] && !cur.soft_rst)
      |=> (cur.read_word[RW_BIT] && cur.read_word[ADDR_MSB:ADDR_LSB]
        == $past(word[ADDR_MSB:ADDR_LSB]))
  ) else $error("read frame did not prepare readback");

  // The output is normal only with both control bits clear.
  state_normal_a: assert property (
    (!cur.gnd_clamp && !cur.three_state && !cur.soft_rst) |=> (output_state == OUT_NORMAL)
  ) else $error("cleared control bits did not give normal mode");

  // Feedback select and amplifier power-down both copy the control bit.
  fb_follow_a: assert property (
    !cur.soft_rst |=> (feedback_resistor_select == $past(cur.fb_sel)
      && amp_power_down == $past(cur.fb_sel))
  ) else $error("feedback outputs do not follow the control bit");

  // A falling clear pin loads the clear code whatever the load pin does.
  pin_clear_a: assert property (
    (clear_fall && !cur.soft_rst) |=> (cur.dac_reg == $past(cur.clear_code))
  ) else $error("clear pin edge did not load the clear code");

  // A falling load pin moves the pending code while the clear pin is high.
  pin_load_a: assert property (
    (load_fall && clear_pin && !cur.soft_rst) |=> (cur.dac_reg == $past(cur.in_reg))
  ) else $error("load pin edge did not move pending code");

  // With the load pin high a DAC write fills only the pending register.
  dac_write_a: assert property (
    (new_frame && is_write_to(word, ADDR_DAC) && load_pin && !clear_fall && !cur.soft_rst)
      |=> ($stable(cur.dac_reg) && cur.in_reg == $past(word_code))
  ) else $error("DAC write bypassed the pending register");

  // A read frame changes no register.
  read_no_write_a: assert property (
    (new_frame && word[RW_BIT] && !do_load && !do_clear && !cur.soft_rst)
      |=> ($stable(cur.dac_reg) && $stable(cur.in_reg) && $stable(cur.clear_code))
  ) else $error("read frame changed a register");

  // The pin emulation register reads back as zero data, since it is write-only.
  write_only_a: assert property (
    (new_frame && word[RW_BIT] && word[ADDR_MSB:ADDR_LSB] == ADDR_SW_PINS && !cur.soft_rst)
      |=> (cur.read_word[CODE_MSB:0] == '0)
  ) else $error("pin emulation register read back data");

  // A software reset also restores the pending code, coding and readout defaults.
  soft_default_a: assert property (
    sw_reset |-> ##2 (cur.in_reg == DAC_REG_RST && cur.code_fmt == CTRL_CODE_FMT_RST
      && cur.fb_sel == CTRL_FB_SEL_RST && cur.readout_off == CTRL_READOUT_OFF_RST
      && dac_code == '0)
  ) else $error("software reset left a register changed");

  // Right after reset the coding, readout, clear code and pending code are at defaults.
  power_on_regs_a: assert property (
    $past(sys_rst) |-> (cur.code_fmt == CTRL_CODE_FMT_RST
      && cur.readout_off == CTRL_READOUT_OFF_RST && cur.clear_code == CLEAR_CODE_RST
      && cur.in_reg == DAC_REG_RST)
  ) else $error("power-on registers are not at defaults");
endmodule

// File: verilog/serial_frame_shifter.sv
`timescale 1ns/1ps
module serial_frame_shifter
  import dac_ctrl_pkg::*;
(
  input wire logic link_clk,
  input wire logic frame_sync_n,
  input wire logic serial_in,
  input wire logic sys_rst,
  serial_frame_if.link bus,
  output logic serial_out,
  output logic serial_out_oe_n
);
  typedef struct packed {
    logic [FRAME_BITS-1:0] shift_in;
    logic [FRAME_BITS-1:0] shift_out;
    logic toggle;
    logic sdo;
    logic oe_n;
  } link_state_t;

  link_state_t cur;
  link_state_t nxt;
  logic [CNT_BITS-1:0] cnt_r;
  logic off_s;

  // The readout disable level comes from the core clock and is resynchronised here.
  sync_2ff #(.WIDTH(1), .RST_VAL(1'h0)) u_off_sync (
    .clk(link_clk),
    .rst(1'b0),
    .d(bus.readout_off),
    .q(off_s)
  );

  // The link clock may stop between frames, so the bit count is cleared by the frame signal.
  always_ff @(posedge link_clk or posedge frame_sync_n) begin
    if (frame_sync_n) begin
      cnt_r <= '0;
    end else if (cnt_r != CNT_BITS'(FRAME_BITS)) begin
      cnt_r <= cnt_r + CNT_BITS'(1);
    end
  end

  // Shift in MSB first; the toggle flips on the last bit so the core sees one event per frame.
  always_comb begin
    nxt = cur;
    if (!frame_sync_n && cnt_r != CNT_BITS'(FRAME_BITS)) begin
      nxt.shift_in = {cur.shift_in[FRAME_BITS-2:0], serial_in};
      if (cnt_r == CNT_BITS'(FRAME_BITS - 1)) begin
        nxt.toggle = ~cur.toggle;
      end
    end
    if (cnt_r == '0) begin
      nxt.sdo = bus.read_word[FRAME_BITS-1];
      nxt.shift_out = {bus.read_word[FRAME_BITS-2:0], 1'b0};
    end else begin
      nxt.sdo = cur.shift_out[FRAME_BITS-1];
      nxt.shift_out = {cur.shift_out[FRAME_BITS-2:0], 1'b0};
    end
    nxt.oe_n = off_s;
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign bus.frame_word = cur.shift_in;
  assign bus.frame_toggle = cur.toggle;
  assign serial_out = cur.sdo;
  assign serial_out_oe_n = cur.oe_n;
endmodule

// File: verilog/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage, giving metastability a full period to settle.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
